// *** hw/twsq_pkg.sv ***
package twsq_pkg;

  // Register byte addresses on the Wishbone bus.
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DATA   = 4'h8;
  localparam logic [3:0] ADDR_MASK   = 4'hc;

  // Control register bit positions.
  localparam int CTRL_FLAG  = 7;
  localparam int CTRL_START = 5;
  localparam int CTRL_STOP  = 4;
  localparam int CTRL_EN    = 2;
  localparam int CTRL_IRQEN = 0;

  // Status register layout: bus code in [7:3], sticky events in [10:8].
  localparam int ST_CODE_LSB  = 3;
  localparam int ST_EV_START  = 8;
  localparam int ST_EV_PACKET = 9;
  localparam int ST_EV_NACK   = 10;

  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_DATA   = 8'h00;
  localparam logic [2:0] RST_MASK   = 3'h0;
  localparam logic [4:0] RST_CODE   = 5'h1f;

  // Bus state codes posted with the flag.
  localparam logic [4:0] CODE_IDLE      = 5'h1f;
  localparam logic [4:0] CODE_START     = 5'h01;
  localparam logic [4:0] CODE_RSTART    = 5'h02;
  localparam logic [4:0] CODE_ADDR_ACK  = 5'h03;
  localparam logic [4:0] CODE_ADDR_NACK = 5'h04;
  localparam logic [4:0] CODE_DATA_ACK  = 5'h05;
  localparam logic [4:0] CODE_DATA_NACK = 5'h06;

  // Quarter bit time: 2.5 us at a 200 MHz clock gives 100 kHz on the bus.
  localparam int         QUARTER_NS    = 2500;
  localparam int         CLK_NS        = 5;
  localparam logic [9:0] QUARTER_TICKS = 10'(QUARTER_NS / CLK_NS);
  localparam logic [3:0] PACKET_BITS   = 4'h9;

  typedef enum logic [2:0] {
    TWSQ_IDLE  = 3'b000,
    TWSQ_START = 3'b001,
    TWSQ_BIT   = 3'b010,
    TWSQ_STOP  = 3'b011,
    TWSQ_HOLD  = 3'b100
  } twsq_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } twsq_pins_t;

endpackage

// *** hw/twsq_sequencer.sv ***
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
module twsq_sequencer
  import twsq_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cpu_global_irq_en_i,
  output logic             irq_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o
);

  logic [7:0]  ctrl;
  logic        flag;
  logic [7:0]  serial_shift_data_reg;
  logic [4:0]  code;
  logic [2:0]  events;
  logic [2:0]  mask;
  logic [2:0]  scl_sync;
  logic [2:0]  sda_sync;
  logic        scl_seen;
  logic        sda_seen;
  twsq_state_t state;
  logic [9:0]  tick;
  logic [1:0]  phase;
  logic [3:0]  bitn;
  logic        is_addr;
  logic        bus_busy;
  twsq_pins_t  drive_low;
  logic        ev_start;
  logic        ev_pkt;
  logic        ev_nack;

  // Bus decode.
  wire access   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_lane0 = access && wb_we_i && wb_sel_i[0];
  wire wr_lane1 = access && wb_we_i && wb_sel_i[1];
  wire wr_ctrl  = wr_lane0 && (wb_adr_i == ADDR_CTRL);
  wire wr_data  = wr_lane0 && (wb_adr_i == ADDR_DATA);
  wire wr_stat  = wr_lane1 && (wb_adr_i == ADDR_STATUS);
  wire wr_mask  = wr_lane1 && (wb_adr_i == ADDR_MASK);
  wire clr_flag = wr_ctrl && wb_dat_i[CTRL_FLAG];
  wire enabled  = ctrl[CTRL_EN];
  wire tick_end = (tick == QUARTER_TICKS - 10'h001);
  wire bit_out  = (bitn == PACKET_BITS - 4'h1) ? 1'b1 : serial_shift_data_reg[7];
  wire set_ev   = ev_start || ev_pkt;
  wire [2:0] ev_clear = wr_stat ? wb_dat_i[ST_EV_NACK:ST_EV_START] : 3'h0;
  wire [2:0] ev_new   = {ev_nack, ev_pkt, ev_start};

  function automatic logic [31:0] read_mux(input logic [3:0] adr);
    case (adr)
      ADDR_CTRL:   read_mux = {24'h0, flag, ctrl[6:0]};
      ADDR_STATUS: read_mux = {21'h0, events, code, 3'h0};
      ADDR_DATA:   read_mux = {24'h0, serial_shift_data_reg};
      ADDR_MASK:   read_mux = {21'h0, mask, 8'h0};
      default:     read_mux = 32'h0;
    endcase
  endfunction

  // Line sampling: three stages, a change counts when the last two agree.
  // A single stage would let one glitchy sample flip a bit on the bus.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync <= 3'h7;
      scl_seen <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_i};
      if (scl_sync[2] == scl_sync[1]) begin
        scl_seen <= scl_sync[2];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_sync <= 3'h7;
      sda_seen <= 1'b1;
    end else begin
      sda_sync <= {sda_sync[1:0], sda_i};
      if (sda_sync[2] == sda_sync[1]) begin
        sda_seen <= sda_sync[2];
      end
    end
  end

  // Wishbone slave: ack one cycle after the strobe, and for one cycle only.
  wire [31:0] rd_word = access ? read_mux(wb_adr_i) : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  // Read data is zero outside the ack cycle, so a stray sample sees nothing stale.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else begin
      wb_dat_o <= rd_word;
    end
  end

  // Shared strobes of the sequencer: the last quarter of a bit time and the ninth bit.
  wire last_quarter = tick_end && (phase == 2'h3);
  wire pkt_last_bit = (bitn == PACKET_BITS - 4'h1);
  wire shift_in     = (state == TWSQ_BIT) && last_quarter && (bitn < 4'h8);
  wire launch_ok    = !flag && !clr_flag && enabled;
  wire tick_clear   = (state == TWSQ_IDLE) || (state == TWSQ_HOLD) || tick_end;
  // A slave that holds the released clock low stretches the high quarters.
  wire stretch      = (state == TWSQ_BIT) && !drive_low.scl && !scl_seen;

  // Control register; start and stop clear themselves once carried out.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl <= {1'b0, wb_dat_i[6:0]};
    end else if (state == TWSQ_START && last_quarter) begin
      ctrl[CTRL_START] <= 1'b0;
    end else if (state == TWSQ_STOP && last_quarter) begin
      ctrl[CTRL_STOP] <= 1'b0;
    end
  end

  // Shared address and data byte; it shifts the line level in as bits go out.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_shift_data_reg <= RST_DATA;
    end else if (wr_data && flag) begin
      serial_shift_data_reg <= wb_dat_i[7:0];
    end else if (shift_in) begin
      serial_shift_data_reg <= {serial_shift_data_reg[6:0], sda_seen};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= RST_MASK;
    end else if (wr_mask) begin
      mask <= wb_dat_i[ST_EV_NACK:ST_EV_START];
    end
  end

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      events <= 3'h0;
    end else begin
      events <= (events & ~ev_clear) | ev_new;
    end
  end

  assign irq_o = flag && ctrl[CTRL_IRQEN] && cpu_global_irq_en_i;

  // Flag: the event set wins over a software clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag <= 1'b0;
    end else if (set_ev) begin
      flag <= 1'b1;
    end else if (clr_flag) begin
      flag <= 1'b0;
    end
  end

  // Bus code reported beside the flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      code <= RST_CODE;
    end else if (ev_start) begin
      code <= bus_busy ? CODE_RSTART : CODE_START;
    end else if (ev_pkt) begin
      code <= is_addr ? (ev_nack ? CODE_ADDR_NACK : CODE_ADDR_ACK)
                      : (ev_nack ? CODE_DATA_NACK : CODE_DATA_ACK);
    end else if (state == TWSQ_IDLE && !bus_busy) begin
      code <= CODE_IDLE;
    end
  end

  // Event strobes at the end of a start and of a packet; a stop posts none.
  assign ev_start = (state == TWSQ_START) && last_quarter;
  assign ev_pkt   = (state == TWSQ_BIT) && last_quarter && pkt_last_bit;
  assign ev_nack  = ev_pkt && sda_seen;

  // Bus sequencer. Each bit time is four quarter phases; the next values are
  // worked out here so that the registers below stay a plain copy.
  twsq_state_t next_state;
  logic [9:0]  next_tick;
  logic [1:0]  next_phase;
  logic [3:0]  next_bitn;
  logic        next_is_addr;
  logic        next_bus_busy;
  twsq_pins_t  next_drive_low;

  always_comb begin
    next_state     = state;
    next_tick      = tick_clear ? 10'h0 : (stretch ? tick : tick + 10'h001);
    next_phase     = phase;
    next_bitn      = bitn;
    next_is_addr   = is_addr;
    next_bus_busy  = bus_busy;
    next_drive_low = drive_low;
    unique case (state)
      TWSQ_IDLE, TWSQ_HOLD: begin
        next_phase = 2'h0;
        next_bitn  = 4'h0;
        // Launch only once the flag is clear, so no operation runs beside it.
        if (launch_ok) begin
          if (ctrl[CTRL_START]) begin
            next_state = TWSQ_START;
          end else if (ctrl[CTRL_STOP] && bus_busy) begin
            next_state = TWSQ_STOP;
          end else if (state == TWSQ_HOLD) begin
            next_state = TWSQ_BIT;
          end
        end
      end
      TWSQ_START: begin
        if (tick_end) begin
          next_phase = phase + 2'h1;
          // Release both, then pull data low with clock high, then clock low.
          unique case (phase)
            2'h0: begin
              next_drive_low = '{scl: 1'b0, sda: 1'b0};
            end
            2'h1: begin
              next_drive_low = '{scl: 1'b0, sda: 1'b1};
            end
            2'h2: begin
              next_drive_low = '{scl: 1'b1, sda: 1'b1};
            end
            2'h3: begin
              next_state    = TWSQ_HOLD;
              next_bus_busy = 1'b1;
              next_is_addr  = 1'b1;
            end
          endcase
        end
      end
      TWSQ_BIT: begin
        if (tick_end) begin
          next_phase = phase + 2'h1;
          // Data moves in the first quarter, while the clock is still held low.
          unique case (phase)
            2'h0: begin
              next_drive_low.sda = !bit_out;
            end
            2'h1: begin
              next_drive_low.scl = 1'b0;
            end
            2'h2: begin
              next_drive_low.scl = 1'b0;
            end
            2'h3: begin
              next_drive_low.scl = 1'b1;
              if (pkt_last_bit) begin
                next_state   = TWSQ_HOLD;
                next_is_addr = 1'b0;
              end
              next_bitn = bitn + 4'h1;
            end
          endcase
        end
      end
      TWSQ_STOP: begin
        if (tick_end) begin
          next_phase = phase + 2'h1;
          // Data low with clock low, release clock, then release data.
          unique case (phase)
            2'h0: begin
              next_drive_low = '{scl: 1'b1, sda: 1'b1};
            end
            2'h1: begin
              next_drive_low = '{scl: 1'b0, sda: 1'b1};
            end
            2'h2: begin
              next_drive_low = '{scl: 1'b0, sda: 1'b0};
            end
            2'h3: begin
              next_state    = TWSQ_IDLE;
              next_bus_busy = 1'b0;
            end
          endcase
        end
      end
      default: next_state = TWSQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= TWSQ_IDLE;
      tick      <= 10'h0;
      phase     <= 2'h0;
      bitn      <= 4'h0;
      is_addr   <= 1'b0;
      bus_busy  <= 1'b0;
      drive_low <= '0;
    end else begin
      state     <= next_state;
      tick      <= next_tick;
      phase     <= next_phase;
      bitn      <= next_bitn;
      is_addr   <= next_is_addr;
      bus_busy  <= next_bus_busy;
      drive_low <= next_drive_low;
    end
  end

  // Open-drain lines: only ever pulled low. Clock stays low while the flag is up.
  assign scl_o    = 1'b0;
  assign sda_o    = 1'b0;
  assign scl_oe_o = drive_low.scl || (flag && bus_busy);
  assign sda_oe_o = drive_low.sda;

endmodule

// *** tb/twsq_slave_model.sv ***
`timescale 1ns/100ps
// Far-side target: samples bits on rising SCL and pulls SDA in the ninth bit if ack_en_i.
module twsq_slave_model (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       ack_en_i,
  output logic            pull_o,
  output logic [7:0]      byte_o,
  output int              starts_o
);
  int         nbit = 0;
  logic [7:0] sh   = 8'h00;
  initial begin
    pull_o = 1'b0;
    byte_o = 8'h00;
    starts_o = 0;
  end
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    starts_o++;
    nbit = 0;
  end
  always @(posedge scl_i) begin
    if (nbit < 8) sh = {sh[6:0], sda_i};
    nbit++;
    if (nbit == 8) byte_o = sh;
  end
  // Released SDA floats high through the pull-up, so no stale value remains.
  always @(negedge scl_i) begin
    pull_o <= (nbit == 8) && ack_en_i;
    if (nbit == 9) nbit = 0;
  end
endmodule

// *** tb/twsq_sequencer_chk.sv ***
`timescale 1ns/100ps
module twsq_sequencer_chk
  import twsq_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        cpu_global_irq_en_i,
  input wire logic        irq_o,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_o,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic ctl = take && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0];
  a_reset_idle: assert property (disable iff (1'b0) rst_i |=>
    !scl_oe_o && !sda_oe_o && !irq_o && !wb_ack_o) else $error("outputs busy after reset");
  a_pins_low: assert property (!scl_o && !sda_o) else $error("pin driven high");
  a_ack_next: assert property (take |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
  a_irq_global: assert property (!cpu_global_irq_en_i |-> !irq_o) else $error("irq ungated");
  a_flag_clear: assert property (ctl && wb_dat_i[CTRL_FLAG] |=> !irq_o) else $error("flag kept");
  a_flag_keep: assert property (irq_o && ctl && !wb_dat_i[CTRL_FLAG] && wb_dat_i[CTRL_IRQEN]
    |=> irq_o || !cpu_global_irq_en_i) else $error("flag lost");
  a_hold_bus: assert property (irq_o && $past(irq_o) |-> scl_oe_o && $stable(sda_oe_o))
    else $error("bus moved while flagged");
  c_flag: cover property ($rose(irq_o));
  c_start: cover property ($rose(sda_oe_o) && !scl_oe_o);
  c_clear: cover property ($fell(irq_o) && cpu_global_irq_en_i);
endmodule
bind twsq_sequencer twsq_sequencer_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
  .cpu_global_irq_en_i(cpu_global_irq_en_i), .scl_i(scl_i), .scl_o(scl_o), .sda_o(sda_o),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_oe_o(sda_oe_o));

// *** tb/twsq_sequencer_tb.sv ***
`timescale 1ns/100ps
module twsq_sequencer_tb;
  import twsq_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, gie = 1, ack_en = 1;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rd, seed = 32'h1d;
  logic [31:0] dat_o;
  logic        ack, irq, scl_o, scl_oe, sda_o, sda_oe, pull;
  logic [7:0]  sbyte;
  int          starts, n_fail = 0, total_checks = 0, cyc_n = 0;
  logic [7:0]  q[$];
  wire logic   scl_w = !scl_oe;
  wire logic   sda_w = !(sda_oe || pull);
  initial forever #2.5 clk_i = !clk_i;
  twsq_sequencer i_twsq_sequencer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .cpu_global_irq_en_i(gie), .irq_o(irq), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe));
  twsq_slave_model i_twsq_slave_model (.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en),
    .pull_o(pull), .byte_o(sbyte), .starts_o(starts));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // The ceiling allows three packets of about 18000 cycles plus the start and stop.
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 80000) begin
      n_fail++;
      give_verdict();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  // Polling, since software cannot rely on the interrupt when it is masked.
  task op(input logic [7:0] c);
    int n;
    n = 0;
    wb(1, ADDR_CTRL, 4'h1, {24'h0, c});
    do begin
      wb(0, ADDR_CTRL, 4'h1, 0);
      n++;
    end while (rd[CTRL_FLAG] !== 1'b1 && n < 9000);
    chk(n < 9000, 1);
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk({irq, scl_oe, sda_oe}, 0);
    wb(0, ADDR_CTRL, 4'h1, 0);
    chk(rd[CTRL_FLAG], 0);
    wb(0, 4'h2, 4'hf, 0);
    chk(rd, 0);
    wb(1, ADDR_MASK, 4'h2, 32'h700);
    wb(0, ADDR_MASK, 4'h2, 0);
    chk(rd & 32'h700, 32'h700);
    op(8'ha5);
    wb(0, ADDR_STATUS, 4'h3, 0);
    chk(rd[7:3], CODE_START);
    chk(starts, 1);
    chk({irq, scl_oe}, 2'b11);
    gie <= 0;
    repeat (2) @(posedge clk_i);
    chk(irq, 0);
    gie <= 1;
    wb(1, ADDR_STATUS, 4'h2, 32'h100);
    wb(0, ADDR_STATUS, 4'h2, 0);
    chk(rd[ST_EV_START], 0);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      ack_en <= (i != 2);
      wb(1, ADDR_DATA, 4'h1, {24'h0, seed[7:0]});
      q.push_back(seed[7:0]);
      wb(1, ADDR_CTRL, 4'h1, 32'h5);
      chk({irq, scl_oe, starts[7:0]}, {2'b11, 8'd1});
      op(8'h85);
      chk(sbyte, q.pop_front());
      wb(0, ADDR_STATUS, 4'h1, 0);
      chk(rd[7:3], i == 0 ? CODE_ADDR_ACK : i == 1 ? CODE_DATA_ACK : CODE_DATA_NACK);
    end
    wb(1, ADDR_CTRL, 4'h1, 32'h95);
    repeat (3000) @(posedge clk_i);
    wb(0, ADDR_CTRL, 4'h1, 0);
    chk({rd[CTRL_FLAG], scl_oe, sda_oe}, 0);
    give_verdict();
  end
endmodule
